// ---- src/edls_sequencer.sv ----
`timescale 1ns/1ps
module edls_sequencer (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   // Configuration
   input  wire logic [7:0]  video_cfg_i,
   input  wire logic [18:0] program_base_pointer_i,
   // Scan timing
   input  wire logic        vsync_i,
   input  wire logic [8:0]  scan_line_i,
   input  wire logic        line_start_i,
   input  wire logic [7:0]  hpos_i,
   // Layer priority inputs
   input  wire logic [7:0]  layer_active_i,
   // Local memory
   output logic              mem_rd_o,
   output logic [18:0]       mem_addr_o,
   input  wire logic        mem_ack_i,
   input  wire logic [7:0]  mem_data_i,
   // Status
   output logic              busy_o,
   output logic              list_done_o,
   // Overlay parameters
   output logic [2:0]        overlay_mode_o,
   output logic              overlay_off_flag_o,
   output logic [18:0]       overlay_row_addr_o,
   output logic [11:0]       overlay_stride_o,
   output logic [7:0]        overlay_hscroll_o,
   output logic [7:0]        overlay_vscroll_o,
   output logic [9:0]        overlay_pixels_o,
   output logic [7:0]        overlay_clocks_o,
   output logic              overlay_window_o,
   output logic              overlay_wins_o,
   output logic [7:0]        font_base_o,
   // Attribute map parameters
   output logic              attr_map_on_o,
   output logic [18:0]       attr_addr_o,
   output logic [11:0]       attr_stride_o,
   output logic [7:0]        attr_hscroll_o,
   output logic [7:0]        attr_vscroll_o,
   output logic [7:0]        attr_cell_w_o,
   output logic [7:0]        attr_cell_h_o,
   // Misc parameters
   output logic [1:0]        width_o,
   output logic [1:0]        pf_palette_o,
   output logic [1:0]        ov_palette_o,
   output logic [7:0]        priority_o
);
   // ****************************************************
   // Types and state
   // ****************************************************
   typedef enum logic [2:0] {
      EDLS_IDLE  = 3'h0,
      EDLS_WAIT  = 3'h1,
      EDLS_FETCH = 3'h2,
      EDLS_LINE  = 3'h3,
      EDLS_DONE  = 3'h4
   } edls_state_type;

   edls_fetch_if fetch ();

   edls_state_type state;
   edls_state_type next_state;
   logic [2:0]  vs_sync;
   logic        vs_seen;
   logic [7:0]  c0;
   logic [7:0]  c1;
   logic [4:0]  idx;
   logic [18:0] ptr;
   logic [8:0]  lines_left;
   logic        req;

   // ****************************************************
   // Byte position decode
   // ****************************************************
   // Byte slot: 0,1 control; 2 repeat; 3-7 ov addr; 8-9 scroll; 10 font;
   // 11-15 attr addr; 16-19 attr layout; 20-21 misc; 22 end of entry
   function automatic logic [4:0] edls_next_slot(input logic [4:0] cur,
                                                 input logic [7:0] b0,
                                                 input logic [7:0] b1);
      logic [4:0] n;
      n = cur + 5'h01;
      if (n == 5'h02 && !b0[edls_pkg::EDLS_C0_REPEAT]) n = 5'h03;
      if (n == 5'h03 && !b0[edls_pkg::EDLS_C0_OVADDR]) n = 5'h08;
      if (n == 5'h08 && !b0[edls_pkg::EDLS_C0_OVERLAY_SCROLL_LOAD]) n = 5'h0A;
      if (n == 5'h0A && !b1[edls_pkg::EDLS_C1_FONT]) n = 5'h0B;
      if (n == 5'h0B && !b1[edls_pkg::EDLS_C1_AMADDR]) n = 5'h10;
      if (n == 5'h10 && !b1[edls_pkg::EDLS_C1_AMLAYOUT]) n = 5'h14;
      if (n == 5'h14 && !b1[edls_pkg::EDLS_C1_MISC]) n = 5'h16;
      return n;
   endfunction

   function automatic logic [1:0] edls_width_decode(input logic [1:0] code);
      return (code == edls_pkg::EDLS_WIDTH_NORMAL || code == edls_pkg::EDLS_WIDTH_WIDE)
             ? code : 2'h0;
   endfunction

   wire vs_rise   = vs_sync[1] & vs_sync[2] & ~vs_seen;
   wire enabled   = video_cfg_i[edls_pkg::EDLS_EN_BIT];
   wire got       = fetch.ack;
   wire [7:0] d   = fetch.data;
   wire [4:0] slot_after = edls_next_slot(idx, (idx == 5'h00) ? d : c0,
                                          (idx == 5'h01) ? d : c1);
   wire entry_end = got && slot_after == 5'h16;
   wire in_text   = overlay_mode_o == edls_pkg::EDLS_MODE_TEXT;

   assign fetch.req  = req;
   assign fetch.addr = ptr;
   assign busy_o     = state != EDLS_IDLE;
   assign list_done_o = state == EDLS_DONE;

   edls_byte_port u_port (
      .clk_i      (clk_i),
      .resetn_i   (resetn_i),
      .fetch      (fetch),
      .mem_rd_o   (mem_rd_o),
      .mem_addr_o (mem_addr_o),
      .mem_ack_i  (mem_ack_i),
      .mem_data_i (mem_data_i)
   );

   // ****************************************************
   // Next state
   // ****************************************************
   always_comb begin
      next_state = state;
      case (state)
         EDLS_IDLE:  if (enabled && vs_rise) next_state = EDLS_WAIT;
         EDLS_WAIT:  if (scan_line_i == edls_pkg::EDLS_START_LINE) next_state = EDLS_FETCH;
         EDLS_FETCH: if (entry_end) next_state = EDLS_LINE;
         EDLS_LINE: begin
            if (line_start_i && lines_left == 9'h000)
               next_state = c1[edls_pkg::EDLS_C1_END] ? EDLS_DONE : EDLS_FETCH;
         end
         EDLS_DONE:  next_state = EDLS_DONE;
         default:    next_state = EDLS_IDLE;
      endcase
      if (!enabled) next_state = EDLS_IDLE;
      else if (vs_rise) next_state = EDLS_WAIT;
   end

   // ****************************************************
   // Sequencer and parameter registers
   // ****************************************************
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state              <= EDLS_IDLE;
         vs_sync            <= 3'h0;
         vs_seen            <= 1'b0;
         c0                 <= 8'h00;
         c1                 <= 8'h00;
         idx                <= 5'h00;
         ptr                <= 19'h00000;
         req                <= 1'b0;
         lines_left         <= 9'h000;
         overlay_mode_o     <= edls_pkg::EDLS_MODE_OFF;
         overlay_off_flag_o <= 1'b1;
         overlay_row_addr_o <= 19'h00000;
         overlay_stride_o   <= 12'h000;
         overlay_hscroll_o  <= 8'h00;
         overlay_vscroll_o  <= 8'h00;
         font_base_o        <= 8'h00;
         attr_map_on_o      <= 1'b0;
         attr_addr_o        <= 19'h00000;
         attr_stride_o      <= 12'h000;
         attr_hscroll_o     <= 8'h00;
         attr_vscroll_o     <= 8'h00;
         attr_cell_w_o      <= edls_pkg::EDLS_CELL_RESET;
         attr_cell_h_o      <= edls_pkg::EDLS_CELL_RESET;
         width_o            <= edls_pkg::EDLS_WIDTH_NORMAL;
         pf_palette_o       <= edls_pkg::EDLS_PF_PAL_RESET;
         ov_palette_o       <= edls_pkg::EDLS_OV_PAL_RESET;
         priority_o         <= edls_pkg::EDLS_PRIO_RESET;
      end else begin
         vs_sync <= {vs_sync[1:0], vsync_i};
         if (vs_sync[1] == vs_sync[2]) vs_seen <= vs_sync[2];
         state <= next_state;
         req   <= 1'b0;
         if (enabled && vs_rise) begin
            ptr               <= program_base_pointer_i;
            idx               <= 5'h00;
            overlay_hscroll_o <= 8'h00;
            overlay_vscroll_o <= 8'h00;
            width_o           <= edls_pkg::EDLS_WIDTH_NORMAL;
            priority_o        <= edls_pkg::EDLS_PRIO_RESET;
            attr_map_on_o     <= 1'b0;
            attr_hscroll_o    <= 8'h00;
            attr_vscroll_o    <= 8'h00;
            attr_cell_w_o     <= edls_pkg::EDLS_CELL_RESET;
            attr_cell_h_o     <= edls_pkg::EDLS_CELL_RESET;
            pf_palette_o      <= edls_pkg::EDLS_PF_PAL_RESET;
            ov_palette_o      <= edls_pkg::EDLS_OV_PAL_RESET;
            overlay_mode_o    <= edls_pkg::EDLS_MODE_OFF;
            // Addresses kept
         end else if (state == EDLS_FETCH) begin
            req <= !got && !req && !fetch.ack;
            if (got) begin
               ptr <= ptr + 19'h00001;
               idx <= (slot_after == 5'h16) ? 5'h00 : slot_after;
               case (idx)
                  5'h00: begin
                     c0         <= d;
                     lines_left <= 9'h000;
                  end
                  5'h01: c1 <= d;
                  5'h02: lines_left <= {1'b0, d};
                  5'h03: overlay_row_addr_o[7:0]   <= d;
                  5'h04: overlay_row_addr_o[15:8]  <= d;
                  5'h05: overlay_row_addr_o[18:16] <= d[2:0];
                  5'h06: overlay_stride_o[7:0]     <= d;
                  5'h07: overlay_stride_o[11:8]    <= d[3:0];
                  5'h08: overlay_hscroll_o         <= d;
                  5'h09: overlay_vscroll_o         <= d;
                  5'h0A: font_base_o               <= d;
                  5'h0B: attr_addr_o[7:0]          <= d;
                  5'h0C: attr_addr_o[15:8]         <= d;
                  5'h0D: attr_addr_o[18:16]        <= d[2:0];
                  5'h0E: attr_stride_o[7:0]        <= {d[7:2], 2'h0};
                  5'h0F: attr_stride_o[11:8]       <= d[3:0];
                  5'h10: attr_hscroll_o            <= d;
                  5'h11: attr_vscroll_o            <= d;
                  5'h12: attr_cell_w_o             <= d;
                  5'h13: attr_cell_h_o             <= d;
                  5'h14: begin
                     pf_palette_o <= d[7:6];
                     ov_palette_o <= d[5:4];
                     width_o      <= edls_width_decode(d[1:0]);
                  end
                  5'h15: priority_o <= d;
                  default: ;
               endcase
               if (slot_after == 5'h16) begin
                  if (c0[edls_pkg::EDLS_C0_TEXT])
                     overlay_mode_o <= edls_pkg::EDLS_MODE_TEXT;
                  else if (!c0[edls_pkg::EDLS_C0_GFX])
                     overlay_mode_o <= edls_pkg::EDLS_MODE_OFF;
                  else if (c1[edls_pkg::EDLS_C1_LORES])
                     overlay_mode_o <= edls_pkg::EDLS_MODE_LORES;
                  else if (c1[edls_pkg::EDLS_C1_HIRES])
                     overlay_mode_o <= edls_pkg::EDLS_MODE_HIRES;
                  else
                     overlay_mode_o <= edls_pkg::EDLS_MODE_STD;
                  overlay_off_flag_o <= c0[edls_pkg::EDLS_C0_OVOFF];
                  if (c0[edls_pkg::EDLS_C0_AMON]) attr_map_on_o <= 1'b1;
                  if (c0[edls_pkg::EDLS_C0_AMOFF]) attr_map_on_o <= 1'b0;
               end
            end
         end else if (state == EDLS_LINE && line_start_i) begin
            if (lines_left != 9'h000) lines_left <= lines_left - 9'h001;
            // Text rows advance on row 7
            if (!in_text || overlay_vscroll_o[2:0] == 3'h7)
               overlay_row_addr_o <= overlay_row_addr_o
                                   + {7'h00, overlay_stride_o};
            if (in_text)
               overlay_vscroll_o <= {5'h00, overlay_vscroll_o[2:0] + 3'h1};
         end
      end
   end

   // ****************************************************
   // Width and resolution decode
   // ****************************************************
   wire is_wide   = width_o == edls_pkg::EDLS_WIDTH_WIDE;
   wire is_normal = width_o == edls_pkg::EDLS_WIDTH_NORMAL;
   wire [7:0] left_edge = is_wide   ? edls_pkg::EDLS_WIDE_LEFT :
                          is_normal ? edls_pkg::EDLS_NORMAL_LEFT :
                                      edls_pkg::EDLS_NARROW_LEFT;
   assign overlay_clocks_o = is_wide   ? edls_pkg::EDLS_CLK_WIDE :
                             is_normal ? edls_pkg::EDLS_CLK_NORMAL :
                                         edls_pkg::EDLS_CLK_NARROW;
   wire [8:0] right_edge = is_wide ? {1'b0, edls_pkg::EDLS_WIDE_RIGHT} :
                           {1'b0, left_edge} + {1'b0, overlay_clocks_o} - 9'h001;
   assign overlay_window_o = busy_o && !overlay_off_flag_o
                           && hpos_i >= left_edge
                           && {1'b0, hpos_i} <= right_edge;
   assign overlay_pixels_o =
      (overlay_mode_o == edls_pkg::EDLS_MODE_STD)   ? edls_pkg::EDLS_PIX_STD :
      (overlay_mode_o == edls_pkg::EDLS_MODE_LORES) ? edls_pkg::EDLS_PIX_LORES :
      (overlay_mode_o == edls_pkg::EDLS_MODE_HIRES) ? edls_pkg::EDLS_PIX_HIRES :
      in_text                                       ? edls_pkg::EDLS_TEXT_COLS :
                                                      10'h000;
   assign overlay_wins_o = |(priority_o & layer_active_i) || layer_active_i == 8'h00;
endmodule

// ---- src/edls_pkg.sv ----
// How it works
// - Sequencer runs only while video configuration bit 0 is set.
// - Each enabled frame the list restarts at the program base pointer.
// - Entry execution begins at scan line 8, after vertical blank.
// - Entry is two control bytes plus enabled optional blocks in fixed order.
// - Loaded parameters persist across entries until reloaded.
// - First byte bit 5 loads repeat count; lines shown = count + 1.
// - First byte bit 6 loads 19-bit overlay address and 12-bit stride.
// - First byte bit 7 loads text scroll bytes, used only in text mode.
// - Second byte bit 0 loads font base bits 18-11.
// - Second byte bit 1 loads attribute map address and stride in fours.
// - Second byte bit 2 loads attribute scroll and cell size minus one.
// - Second byte bit 3 loads width, palettes and priority.
// - Second byte bit 7 ends list processing for the frame.
// - Vertical sync restarts fetching from the program base pointer.
// - Frame start restores parameter defaults except font base, addresses, strides and overlay off flag.
// - Overlay and attribute map addresses are kept across frames.
// - Overlay mode comes from text, graphics, low and high resolution flags.
// - Graphics modes give 320, 160 or 640 pixels at normal width.
// - Text mode gives 80 columns of character and attribute pairs.
// - Widths span 128, 160 or 184 color clocks.
// - Wide overlay covers horizontal positions 0x2C through 0xD3.
// - Stride advances row address each line (only on row 7 in text mode), 0 to 4095.
// - Overlay wins when any active layer has its priority bit set, or when no layer is active.
package edls_pkg;
   localparam logic [8:0]  EDLS_START_LINE    = 9'h008;
   localparam int          EDLS_EN_BIT        = 0;
   localparam int          EDLS_C0_TEXT       = 0;
   localparam int          EDLS_C0_GFX        = 1;
   localparam int          EDLS_C0_OVOFF      = 2;
   localparam int          EDLS_C0_AMON       = 3;
   localparam int          EDLS_C0_AMOFF      = 4;
   localparam int          EDLS_C0_REPEAT     = 5;
   localparam int          EDLS_C0_OVADDR     = 6;
   localparam int          EDLS_C0_OVERLAY_SCROLL_LOAD   = 7;
   localparam int          EDLS_C1_FONT       = 0;
   localparam int          EDLS_C1_AMADDR     = 1;
   localparam int          EDLS_C1_AMLAYOUT   = 2;
   localparam int          EDLS_C1_MISC       = 3;
   localparam int          EDLS_C1_LORES      = 4;
   localparam int          EDLS_C1_HIRES      = 5;
   localparam int          EDLS_C1_END        = 7;
   localparam logic [1:0]  EDLS_WIDTH_NORMAL  = 2'h1;
   localparam logic [1:0]  EDLS_WIDTH_WIDE    = 2'h2;
   localparam logic [7:0]  EDLS_PRIO_RESET    = 8'hFF;
   localparam logic [7:0]  EDLS_CELL_RESET    = 8'h07;
   localparam logic [1:0]  EDLS_PF_PAL_RESET  = 2'h0;
   localparam logic [1:0]  EDLS_OV_PAL_RESET  = 2'h1;
   localparam logic [7:0]  EDLS_CLK_NARROW    = 8'h80;
   localparam logic [7:0]  EDLS_CLK_NORMAL    = 8'hA0;
   localparam logic [7:0]  EDLS_CLK_WIDE      = 8'hB8;
   localparam logic [7:0]  EDLS_NARROW_LEFT   = 8'h40;
   localparam logic [7:0]  EDLS_NORMAL_LEFT   = 8'h30;
   localparam logic [7:0]  EDLS_WIDE_LEFT     = 8'h2C;
   localparam logic [7:0]  EDLS_WIDE_RIGHT    = 8'hD3;
   localparam logic [9:0]  EDLS_PIX_STD       = 10'h140;
   localparam logic [9:0]  EDLS_PIX_LORES     = 10'h0A0;
   localparam logic [9:0]  EDLS_PIX_HIRES     = 10'h280;
   localparam logic [9:0]  EDLS_TEXT_COLS     = 10'h050;

   typedef enum logic [2:0] {
      EDLS_MODE_OFF   = 3'h0,
      EDLS_MODE_STD   = 3'h1,
      EDLS_MODE_LORES = 3'h2,
      EDLS_MODE_HIRES = 3'h3,
      EDLS_MODE_TEXT  = 3'h4
   } edls_mode_type;
endpackage

// ---- src/edls_fetch_if.sv ----
`timescale 1ns/1ps
// Byte fetch channel
interface edls_fetch_if;
   logic        req;
   logic [18:0] addr;
   logic        ack;
   logic [7:0]  data;
   modport seq (output req, output addr, input ack, input data);
   modport mem (input req, input addr, output ack, output data);
endinterface

// ---- src/edls_byte_port.sv ----
`timescale 1ns/1ps
// One outstanding read, data registered
module edls_byte_port (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   // Sequencer side
   edls_fetch_if.mem         fetch,
   // Local memory side
   output logic              mem_rd_o,
   output logic [18:0]       mem_addr_o,
   input  wire logic        mem_ack_i,
   input  wire logic [7:0]  mem_data_i
);
   logic       busy;
   logic       ack;
   logic [7:0] data;
   logic [18:0] addr;

   assign mem_rd_o   = busy;
   assign mem_addr_o = addr;
   assign fetch.ack  = ack;
   assign fetch.data = data;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         busy <= 1'b0;
         ack  <= 1'b0;
         data <= 8'h00;
         addr <= 19'h00000;
      end else begin
         ack <= 1'b0;
         if (busy && mem_ack_i) begin
            busy <= 1'b0;
            ack  <= 1'b1;
            data <= mem_data_i;
         end else if (!busy && !ack && fetch.req) begin
            busy <= 1'b1;
            addr <= fetch.addr;
         end
      end
   end
endmodule

// ---- sim/edls_mem_model.sv ----
`timescale 1ns/1ps
// ***************
// Local memory model
// ***************
module edls_mem_model (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   // Read port
   input  wire logic        mem_rd_i,
   input  wire logic [18:0] mem_addr_i,
   input  wire logic [1:0]  lat_i,
   output logic             mem_ack_o,
   output logic [7:0]       mem_data_o
);
   logic [7:0] mem [0:255];
   logic [1:0] wait_cnt;
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wait_cnt <= 2'h0;
         mem_ack_o <= 1'b0;
         mem_data_o <= 8'h00;
      end else begin
         mem_ack_o <= 1'b0;
         // Idle data toggles
         mem_data_o <= ~mem_data_o;
         if (mem_rd_i && !mem_ack_o && wait_cnt >= lat_i) begin
            mem_ack_o <= 1'b1;
            mem_data_o <= mem[mem_addr_i[7:0]];
            wait_cnt <= 2'h0;
         end else if (mem_rd_i && !mem_ack_o) begin
            wait_cnt <= wait_cnt + 2'h1;
         end
      end
   end
endmodule

// ---- sim/edls_sequencer_checker.sv ----
`timescale 1ns/1ps
module edls_sequencer_checker (
   // Clock and reset
   input wire logic        clk_i,
   input wire logic        resetn_i,
   // Inputs
   input wire logic [7:0]  video_cfg_i,
   input wire logic [18:0] program_base_pointer_i,
   input wire logic        vsync_i,
   input wire logic [8:0]  scan_line_i,
   input wire logic [7:0]  hpos_i,
   input wire logic [7:0]  layer_active_i,
   input wire logic        mem_ack_i,
   // Outputs
   input wire logic        mem_rd_o,
   input wire logic [18:0] mem_addr_o,
   input wire logic        busy_o,
   input wire logic [2:0]  overlay_mode_o,
   input wire logic        overlay_off_flag_o,
   input wire logic [18:0] overlay_row_addr_o,
   input wire logic [9:0]  overlay_pixels_o,
   input wire logic [7:0]  overlay_clocks_o,
   input wire logic        overlay_window_o,
   input wire logic        overlay_wins_o,
   input wire logic [18:0] attr_addr_o,
   input wire logic        attr_map_on_o,
   input wire logic [1:0]  width_o,
   input wire logic [1:0]  ov_palette_o,
   input wire logic [7:0]  priority_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   // First fetch of a frame still pending
   logic first_pend;
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         first_pend <= 1'b0;
      end else if (scan_line_i < edls_pkg::EDLS_START_LINE) begin
         first_pend <= 1'b1;
      end else if (mem_rd_o) begin
         first_pend <= 1'b0;
      end
   end
   chk_cfg_idle: assert property (!video_cfg_i[0] ##1 !video_cfg_i[0] |=> !busy_o)
      else $error("sequencer active while disabled");
   chk_cfg_noread: assert property (!video_cfg_i[0] [*3] ##0 !mem_rd_o |=> !mem_rd_o)
      else $error("read while disabled");
   chk_read_hold: assert property (mem_rd_o && !mem_ack_i && video_cfg_i[0] |=>
      mem_rd_o && $stable(mem_addr_o)) else $error("read dropped before ack");
   chk_ack_gap: assert property (mem_ack_i && mem_rd_o |=> !mem_rd_o [*2])
      else $error("read too soon after ack");
   chk_start_line: assert property (scan_line_i < edls_pkg::EDLS_START_LINE |-> !$rose(mem_rd_o))
      else $error("fetch before start line");
   chk_frame_base: assert property ($rose(mem_rd_o) && first_pend |->
      mem_addr_o == program_base_pointer_i) else $error("frame fetch not at base");
   chk_frame_defaults: assert property ($rose(vsync_i) |-> ##[2:8] (width_o == 2'h1 &&
      priority_o == 8'hFF && ov_palette_o == 2'h1 && !attr_map_on_o)) else $error("no defaults");
   chk_addr_kept: assert property ($rose(vsync_i) |=>
      ($stable(overlay_row_addr_o) && $stable(attr_addr_o)) [*8]) else $error("address lost");
   chk_clock_span: assert property (overlay_clocks_o == (width_o == 2'h0 ? 8'h80 :
      width_o == 2'h1 ? 8'hA0 : 8'hB8)) else $error("wrong clock span");
   chk_wide_span: assert property (width_o == 2'h2 && busy_o && !overlay_off_flag_o |->
      overlay_window_o ==
      (hpos_i >= 8'h2C && hpos_i <= 8'hD3)) else $error("wrong wide window");
   chk_pixel_count: assert property (overlay_mode_o != 3'h0 |-> overlay_pixels_o ==
      (overlay_mode_o == 3'h1 ? 10'h140 : overlay_mode_o == 3'h2 ? 10'h0A0 :
      overlay_mode_o == 3'h3 ? 10'h280 : 10'h050)) else $error("wrong pixel count");
   chk_layer_prio: assert property (overlay_wins_o ==
      ((|(priority_o & layer_active_i)) || layer_active_i == 8'h00)) else $error("wrong priority");
   cover property ($rose(mem_rd_o) && first_pend);
   cover property (width_o == 2'h2 && overlay_window_o);
   cover property (overlay_mode_o == 3'h4);
endmodule
bind edls_sequencer edls_sequencer_checker chk_u (.clk_i(clk_i), .resetn_i(resetn_i),
   .video_cfg_i(video_cfg_i), .program_base_pointer_i(program_base_pointer_i),
   .vsync_i(vsync_i), .scan_line_i(scan_line_i), .hpos_i(hpos_i),
   .layer_active_i(layer_active_i), .mem_ack_i(mem_ack_i), .mem_rd_o(mem_rd_o),
   .mem_addr_o(mem_addr_o), .busy_o(busy_o), .overlay_mode_o(overlay_mode_o),
   .overlay_off_flag_o(overlay_off_flag_o),
   .overlay_row_addr_o(overlay_row_addr_o), .overlay_pixels_o(overlay_pixels_o),
   .overlay_clocks_o(overlay_clocks_o), .overlay_window_o(overlay_window_o),
   .overlay_wins_o(overlay_wins_o), .attr_addr_o(attr_addr_o), .attr_map_on_o(attr_map_on_o),
   .width_o(width_o), .ov_palette_o(ov_palette_o), .priority_o(priority_o));

// ---- sim/tb_edls_sequencer.sv ----
`timescale 1ns/1ps
module tb_edls_sequencer;
   logic        clk_i = 1'b0, resetn_i = 1'b0, vsync_i = 1'b0, line_start_i = 1'b0;
   logic [7:0]  video_cfg_i = 8'h00, hpos_i = 8'h00, layer_i = 8'h00;
   logic [18:0] base_i = 19'h00010, ea, mem_addr, row, aaddr;
   logic [8:0]  scan_line_i = 9'h000;
   logic [1:0]  lat = 2'h0, width, pfpal, ovpal;
   logic [15:0] noise = 16'h0017, rnd = 16'h0017;
   logic        mem_rd, mem_ack, busy, done, ovoff, amon;
   logic [7:0]  mem_data, hs, vs, font, ahs, avs, cw, ch, prio, r;
   logic [11:0] st, ast;
   logic [2:0]  mode;
   logic [7:0]  b [0:24];
   int          mismatches = 0, checked = 0, cycles = 0;
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [1:0] exp_width(input logic [1:0] c);
      return (c == 2'h3) ? 2'h0 : c;
   endfunction
   function automatic logic [2:0] exp_mode(input int m);
      return m == 0 ? edls_pkg::EDLS_MODE_STD : m == 1 ? edls_pkg::EDLS_MODE_LORES
         : edls_pkg::EDLS_MODE_HIRES;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic wait_acks(input int n);
      while (n > 0) begin
         @(posedge clk_i);
         if (mem_ack === 1'b1) n--;
      end
      repeat (4) @(posedge clk_i);
   endtask
   task automatic line();
      line_start_i <= 1'b1;
      scan_line_i <= scan_line_i + 9'h001;
      @(posedge clk_i);
      line_start_i <= 1'b0;
      repeat (14) @(posedge clk_i);
   endtask
   initial forever #2 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      noise <= lfsr(noise);
      hpos_i <= noise[7:0];
      layer_i <= noise[15:8];
      lat <= noise[9:8];
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         complete_run();
      end
   end
   edls_mem_model mem_u (.clk_i(clk_i), .resetn_i(resetn_i), .mem_rd_i(mem_rd),
      .mem_addr_i(mem_addr), .lat_i(lat), .mem_ack_o(mem_ack), .mem_data_o(mem_data));
   edls_sequencer uut (.clk_i(clk_i), .resetn_i(resetn_i), .video_cfg_i(video_cfg_i),
      .program_base_pointer_i(base_i), .vsync_i(vsync_i), .scan_line_i(scan_line_i),
      .line_start_i(line_start_i), .hpos_i(hpos_i), .layer_active_i(layer_i),
      .mem_rd_o(mem_rd), .mem_addr_o(mem_addr), .mem_ack_i(mem_ack), .mem_data_i(mem_data),
      .busy_o(busy), .list_done_o(done), .overlay_mode_o(mode), .overlay_off_flag_o(ovoff),
      .overlay_row_addr_o(row), .overlay_stride_o(st), .overlay_hscroll_o(hs),
      .overlay_vscroll_o(vs), .overlay_pixels_o(), .overlay_clocks_o(), .overlay_window_o(),
      .overlay_wins_o(), .font_base_o(font), .attr_map_on_o(amon), .attr_addr_o(aaddr),
      .attr_stride_o(ast), .attr_hscroll_o(ahs), .attr_vscroll_o(avs), .attr_cell_w_o(cw),
      .attr_cell_h_o(ch), .width_o(width), .pf_palette_o(pfpal), .ov_palette_o(ovpal),
      .priority_o(prio));
   initial begin
      repeat (6) @(posedge clk_i);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      check({width, prio, pfpal, ovpal, mode}, {2'h1, 8'hFF, 2'h0, 2'h1, 3'h0});
      video_cfg_i <= 8'h01;
      for (int f = 0; f < 5; f++) begin
         r = (f == 0) ? 8'hFF : {5'h00, rnd[2:0]};
         for (int i = 2; i < 22; i++) begin
            rnd = lfsr(rnd);
            b[i] = rnd[7:0];
         end
         b[0] = 8'hEE;
         b[1] = 8'h0F | (f % 3 == 1 ? 8'h10 : f % 3 == 2 ? 8'h20 : 8'h00);
         b[2] = r;
         b[20][3:0] = {2'h0, 2'(f)};
         {b[22], b[23], b[24]} = {8'h31, 8'h80, 8'h00};
         for (int i = 0; i < 25; i++) mem_u.mem[8'h10 + 8'(f * 32) + 8'(i)] = b[i];
         base_i <= 19'h00010 + 19'(f * 32);
         vsync_i <= 1'b1;
         scan_line_i <= 9'h000;
         repeat (4) @(posedge clk_i);
         vsync_i <= 1'b0;
         repeat (10) @(posedge clk_i);
         scan_line_i <= 9'h008;
         if (f == 4) begin
            wait_acks(3);
            video_cfg_i <= 8'h00;
            repeat (8) @(posedge clk_i);
            check({busy, mem_rd}, 2'h0);
         end else begin
            wait_acks(22);
            check(row, {b[5][2:0], b[4], b[3]});
            check(st, {b[7][3:0], b[6]});
            check({hs, vs}, {b[8], b[9]});
            check(font, b[10]);
            check(aaddr, {b[13][2:0], b[12], b[11]});
            check(ast, {b[15][3:0], b[14][7:2], 2'b00});
            check({ahs, avs, cw, ch}, {b[16], b[17], b[18], b[19]});
            check({width, pfpal, ovpal, prio}, {exp_width(b[20][1:0]), b[20][7:4], b[21]});
            check(mode, exp_mode(f % 3));
            check({ovoff, amon}, 2'h3);
            ea = row;
            for (int k = 1; k <= r; k++) begin
               line();
               ea = ea + 19'(st);
               check(row, ea);
            end
            check(mem_rd, 1'b0);
            line_start_i <= 1'b1;
            @(posedge clk_i);
            line_start_i <= 1'b0;
            wait_acks(3);
            check(mode, edls_pkg::EDLS_MODE_TEXT);
            check({ovoff, amon}, 2'h0);
            check({font, prio, width}, {b[10], b[21], exp_width(b[20][1:0])});
            line();
            check({done, mem_rd}, 2'h2);
         end
      end
      complete_run();
   end
endmodule
